// *** hdl/otp_prog_pkg.sv ***
// Constants for the one-time-programmable memory programmer
package otp_prog_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int ID_CODE_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PULSE_US = 100;
  localparam int PULSE_MIN_US = 95;
  localparam int PULSE_MAX_US = 105;
  localparam int SETUP_US = 2;
  localparam int OE_VALID_NS = 150;
  localparam int FLOAT_NS = 130;
  localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_MAX_CYC = PULSE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int SETUP_CYC = SETUP_US * (CLK_HZ / 1_000_000);
  localparam int OE_VALID_CYC =
    (OE_VALID_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FLOAT_CYC =
    (FLOAT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ----------------------------------------------------------------
  // Retry limit
  // ----------------------------------------------------------------
  localparam int MAX_RETRY = 10;

  // ----------------------------------------------------------------
  // Supply level selections
  // ----------------------------------------------------------------
  localparam logic [1:0] SUPPLY_NORMAL = 2'h0;
  localparam logic [1:0] SUPPLY_PROGRAM = 2'h1;
  localparam logic [1:0] SUPPLY_ID = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_POWER_UP  = 4'h1,
    ST_SETUP     = 4'h2,
    ST_PULSE     = 4'h3,
    ST_HOLD      = 4'h4,
    ST_VERIFY    = 4'h5,
    ST_SAMPLE    = 4'h6,
    ST_FLOAT     = 4'h7,
    ST_POWER_DN  = 4'h8,
    ST_FINAL     = 4'h9,
    ST_FIN_SMP   = 4'ha,
    ST_DONE      = 4'hb,
    ST_ID_READ   = 4'hc,
    ST_ID_SMP    = 4'hd
  } prog_state_t;

  typedef enum logic [1:0] {
    PH_FIRST  = 2'h0,
    PH_VERIFY = 2'h1,
    PH_FINAL  = 2'h2
  } phase_t;

endpackage : otp_prog_pkg

// *** hdl/otp_delay_timer.sv ***
// Down-counting delay timer with one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module otp_delay_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Control
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  // Status
  output logic                  done_out
);

  initial
  begin
    if (CNT_W < 2)
      $error("otp_delay_timer: CNT_W too small");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             run_reg;
  logic             run_next;
  logic             done_reg;
  logic             done_next;

  always_comb
  begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    done_next = 1'b0;
    if (load_in)
    begin
      cnt_next = count_in;
      run_next = 1'b1;
    end
    else if (run_reg)
    begin
      if (cnt_reg <= CNT_W'(1))
      begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end
      else
        cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      done_reg <= done_next;
    end
  end

  assign done_out = done_reg;

endmodule : otp_delay_timer
`default_nettype wire

// *** hdl/otp_programmer.sv ***
// Programmer controller for a 256K x 8 one-time-programmable memory
//
// Summary of operation
// - Start programming at the lowest array address before any strobe.
// - Raise core to 6.5V and programming supply to 13.0V first.
// - Each program strobe low pulse lasts 95 to 105 us, nominal 100.
// - First pass: one nominal pulse per address, no read-back.
// - Then verify every address again from the lowest, reprogram on mismatch.
// - On mismatch apply single extra pulses, up to ten, verifying each.
// - Still wrong after ten retries: stop, report the part failed.
// - Good byte advances address; loop ends after the last address.
// - After the loop return both supplies to the normal level.
// - Read every byte at normal supply, compare, declare pass or fail.
// - Identification voltage on id line; code bit selects maker or part.
`timescale 1ns/1ps
`default_nettype none
module otp_programmer #(
  parameter int ADDR_W = otp_prog_pkg::ADDR_W,
  parameter int PULSE_CYC = otp_prog_pkg::PULSE_CYC,
  parameter int SETUP_CYC = otp_prog_pkg::SETUP_CYC,
  parameter int MAX_RETRY = otp_prog_pkg::MAX_RETRY
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              arst_n_in,
  // User command
  input  wire logic              start_prog_in,
  input  wire logic              start_id_in,
  input  wire logic [ADDR_W-1:0] last_addr_in,
  // Source data lookup
  output logic [ADDR_W-1:0]      src_addr_out,
  input  wire logic [7:0]        src_data_in,
  // Status
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   pass_out,
  output logic                   fail_out,
  output logic [ADDR_W-1:0]      fail_addr_out,
  output logic [7:0]             maker_code_out,
  output logic [7:0]             part_code_out,
  output logic                   id_valid_out,
  // Memory pins
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic [7:0]             mem_data_out,
  output logic                   mem_data_oe_n_out,
  input  wire logic [7:0]        mem_data_in,
  output logic                   chip_select_n_out,
  output logic                   output_enable_n_out,
  output logic                   program_strobe_n_out,
  // Supply and identification voltage switches
  output logic [1:0]             vcc_sel_out,
  output logic [1:0]             vpp_sel_out,
  output logic                   identification_high_voltage_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int TW = 12;
  initial
  begin
    if (PULSE_CYC < otp_prog_pkg::PULSE_MIN_CYC && PULSE_CYC < 2)
      $error("otp_programmer: PULSE_CYC too small");
    if (PULSE_CYC >= (1 << TW) || SETUP_CYC >= (1 << TW))
      $error("otp_programmer: timer too narrow");
    if (MAX_RETRY < 1 || MAX_RETRY > 15)
      $error("otp_programmer: MAX_RETRY out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  otp_prog_pkg::prog_state_t st_reg, st_next;
  otp_prog_pkg::phase_t      ph_reg, ph_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0]        retry_reg, retry_next;
  logic [7:0]        dout_reg, dout_next;
  logic              doe_n_reg, doe_n_next;
  logic              cs_n_reg, cs_n_next;
  logic              oe_n_reg, oe_n_next;
  logic              pgm_n_reg, pgm_n_next;
  logic [1:0]        vcc_reg, vcc_next;
  logic [1:0]        vpp_reg, vpp_next;
  logic              vid_reg, vid_next;
  logic              busy_reg, busy_next;
  logic              done_reg, done_next;
  logic              pass_reg, pass_next;
  logic              fail_reg, fail_next;
  logic [ADDR_W-1:0] faddr_reg, faddr_next;
  logic [7:0]        maker_reg, maker_next;
  logic [7:0]        part_reg, part_next;
  logic              idv_reg, idv_next;
  logic              tload;
  logic [TW-1:0]     tcount;
  logic              tdone;
  logic              rs1_reg, rst_n;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end

  otp_delay_timer #(
    .CNT_W(TW)
  ) u_timer (
    .clk_in  (clk_sys_in),
    .rst_n_in(rst_n),
    .load_in (tload),
    .count_in(tcount),
    .done_out(tdone)
  );

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n < 1 ? 1 : n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    ph_next = ph_reg;
    addr_next = addr_reg;
    retry_next = retry_reg;
    dout_next = dout_reg;
    doe_n_next = doe_n_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    pgm_n_next = pgm_n_reg;
    vcc_next = vcc_reg;
    vpp_next = vpp_reg;
    vid_next = vid_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    pass_next = pass_reg;
    fail_next = fail_reg;
    faddr_next = faddr_reg;
    maker_next = maker_reg;
    part_next = part_reg;
    idv_next = idv_reg;
    tload = 1'b0;
    tcount = cyc(SETUP_CYC);
    case (st_reg)
      otp_prog_pkg::ST_IDLE:
      begin
        if (start_prog_in)
        begin
          addr_next = '0;
          vcc_next = otp_prog_pkg::SUPPLY_PROGRAM;
          vpp_next = otp_prog_pkg::SUPPLY_PROGRAM;
          ph_next = otp_prog_pkg::PH_FIRST;
          busy_next = 1'b1;
          pass_next = 1'b0;
          fail_next = 1'b0;
          tload = 1'b1;
          st_next = otp_prog_pkg::ST_POWER_UP;
        end
        else if (start_id_in)
        begin
          // Raise id line, select maker code
          vid_next = 1'b1;
          addr_next = '0;
          idv_next = 1'b0;
          busy_next = 1'b1;
          cs_n_next = 1'b0;
          oe_n_next = 1'b0;
          tload = 1'b1;
          st_next = otp_prog_pkg::ST_ID_READ;
        end
      end
      otp_prog_pkg::ST_POWER_UP:
        if (tdone)
        begin
          dout_next = src_data_in;
          doe_n_next = 1'b0;
          cs_n_next = 1'b0;
          tload = 1'b1;
          st_next = otp_prog_pkg::ST_SETUP;
        end
      otp_prog_pkg::ST_SETUP:
        if (tdone)
        begin
          // Nominal width; timer adds a cycle
          pgm_n_next = 1'b0;
          tload = 1'b1;
          tcount = cyc(PULSE_CYC - 1);
          st_next = otp_prog_pkg::ST_PULSE;
        end
      otp_prog_pkg::ST_PULSE:
        if (tdone)
        begin
          pgm_n_next = 1'b1;
          tload = 1'b1;
          st_next = otp_prog_pkg::ST_HOLD;
        end
      otp_prog_pkg::ST_HOLD:
        if (tdone)
        begin
          doe_n_next = 1'b1;
          if (ph_reg == otp_prog_pkg::PH_FIRST)
          begin
            // One pulse per address, no read
            if (addr_reg == last_addr_in)
            begin
              addr_next = '0;
              retry_next = '0;
              ph_next = otp_prog_pkg::PH_VERIFY;
              tload = 1'b1;
              st_next = otp_prog_pkg::ST_VERIFY;
            end
            else
            begin
              addr_next = addr_reg + ADDR_W'(1);
              tload = 1'b1;
              st_next = otp_prog_pkg::ST_POWER_UP;
            end
          end
          else
          begin
            tload = 1'b1;
            st_next = otp_prog_pkg::ST_VERIFY;
          end
        end
      otp_prog_pkg::ST_VERIFY:
        if (tdone)
        begin
          // Strobe high, select and enable low
          pgm_n_next = 1'b1;
          cs_n_next = 1'b0;
          oe_n_next = 1'b0;
          tload = 1'b1;
          tcount = cyc(otp_prog_pkg::OE_VALID_CYC);
          st_next = otp_prog_pkg::ST_SAMPLE;
        end
      otp_prog_pkg::ST_SAMPLE:
        if (tdone)
        begin
          oe_n_next = 1'b1;
          tload = 1'b1;
          tcount = cyc(otp_prog_pkg::FLOAT_CYC);
          st_next = otp_prog_pkg::ST_FLOAT;
          if (mem_data_in == src_data_in)
          begin
            retry_next = '0;
            if (addr_reg == last_addr_in)
            begin
              vcc_next = otp_prog_pkg::SUPPLY_NORMAL;
              vpp_next = otp_prog_pkg::SUPPLY_NORMAL;
              tcount = cyc(SETUP_CYC);
              st_next = otp_prog_pkg::ST_POWER_DN;
            end
            else
              addr_next = addr_reg + ADDR_W'(1);
          end
          else if (retry_reg == 4'(MAX_RETRY))
          begin
            fail_next = 1'b1;
            faddr_next = addr_reg;
            vcc_next = otp_prog_pkg::SUPPLY_NORMAL;
            vpp_next = otp_prog_pkg::SUPPLY_NORMAL;
            st_next = otp_prog_pkg::ST_DONE;
          end
          else
          begin
            retry_next = retry_reg + 4'h1;
            tcount = cyc(SETUP_CYC);
            dout_next = src_data_in;
            doe_n_next = 1'b0;
            st_next = otp_prog_pkg::ST_SETUP;
          end
        end
      otp_prog_pkg::ST_FLOAT:
        // Wait for device to float bus
        if (tdone)
        begin
          tload = 1'b1;
          st_next = otp_prog_pkg::ST_VERIFY;
        end
      otp_prog_pkg::ST_POWER_DN:
        if (tdone)
        begin
          addr_next = '0;
          ph_next = otp_prog_pkg::PH_FINAL;
          cs_n_next = 1'b0;
          oe_n_next = 1'b0;
          tload = 1'b1;
          tcount = cyc(otp_prog_pkg::OE_VALID_CYC);
          st_next = otp_prog_pkg::ST_FIN_SMP;
        end
      otp_prog_pkg::ST_FIN_SMP:
        if (tdone)
        begin
          if (mem_data_in != src_data_in)
          begin
            fail_next = 1'b1;
            faddr_next = addr_reg;
            st_next = otp_prog_pkg::ST_DONE;
          end
          else if (addr_reg == last_addr_in)
          begin
            pass_next = 1'b1;
            st_next = otp_prog_pkg::ST_DONE;
          end
          else
          begin
            // Address change under steady enables; wait full valid time
            addr_next = addr_reg + ADDR_W'(1);
            tload = 1'b1;
            tcount = cyc(otp_prog_pkg::OE_VALID_CYC);
          end
        end
      otp_prog_pkg::ST_ID_READ, otp_prog_pkg::ST_ID_SMP:
        if (tdone)
        begin
          // Code bit low maker, high part
          if (st_reg == otp_prog_pkg::ST_ID_READ)
          begin
            maker_next = mem_data_in;
            addr_next = ADDR_W'(1) << otp_prog_pkg::ID_CODE_BIT;
            tload = 1'b1;
            st_next = otp_prog_pkg::ST_ID_SMP;
          end
          else
          begin
            part_next = mem_data_in;
            idv_next = 1'b1;
            vid_next = 1'b0;
            st_next = otp_prog_pkg::ST_DONE;
          end
        end
      otp_prog_pkg::ST_DONE:
      begin
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        pgm_n_next = 1'b1;
        doe_n_next = 1'b1;
        busy_next = 1'b0;
        done_next = 1'b1;
        st_next = otp_prog_pkg::ST_IDLE;
      end
      default:
        st_next = otp_prog_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= otp_prog_pkg::ST_IDLE;
      ph_reg <= otp_prog_pkg::PH_FIRST;
      addr_reg <= '0;
      retry_reg <= '0;
      dout_reg <= '0;
      doe_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      pgm_n_reg <= 1'b1;
      vcc_reg <= otp_prog_pkg::SUPPLY_NORMAL;
      vpp_reg <= otp_prog_pkg::SUPPLY_NORMAL;
      vid_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
      fail_reg <= 1'b0;
      faddr_reg <= '0;
      maker_reg <= '0;
      part_reg <= '0;
      idv_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      addr_reg <= addr_next;
      retry_reg <= retry_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      pgm_n_reg <= pgm_n_next;
      vcc_reg <= vcc_next;
      vpp_reg <= vpp_next;
      vid_reg <= vid_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      pass_reg <= pass_next;
      fail_reg <= fail_next;
      faddr_reg <= faddr_next;
      maker_reg <= maker_next;
      part_reg <= part_next;
      idv_reg <= idv_next;
    end
  end

  assign src_addr_out = addr_reg;
  assign mem_addr_out = addr_reg;
  assign mem_data_out = dout_reg;
  assign mem_data_oe_n_out = doe_n_reg;
  assign chip_select_n_out = cs_n_reg;
  assign output_enable_n_out = oe_n_reg;
  assign program_strobe_n_out = pgm_n_reg;
  assign vcc_sel_out = vcc_reg;
  assign vpp_sel_out = vpp_reg;
  assign identification_high_voltage_out = vid_reg;
  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign pass_out = pass_reg;
  assign fail_out = fail_reg;
  assign fail_addr_out = faddr_reg;
  assign maker_code_out = maker_reg;
  assign part_code_out = part_reg;
  assign id_valid_out = idv_reg;

endmodule : otp_programmer
`default_nettype wire

// *** sim/otp_programmer_checker.sv ***
// Assertion checker bound to the memory programmer ports
`timescale 1ns/1ps
`default_nettype none
module otp_programmer_checker #(
  parameter int ADDR_W    = 18,
  parameter int PULSE_CYC = 2000,
  parameter int MAX_RETRY = 10
) (
  // Clock and reset
  input wire logic              clk_sys_in,
  input wire logic              arst_n_in,
  // Status
  input wire logic              busy_out,
  input wire logic              done_out,
  input wire logic              pass_out,
  input wire logic              fail_out,
  // Memory pins and supplies
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic              mem_data_oe_n_out,
  input wire logic              output_enable_n_out,
  input wire logic              program_strobe_n_out,
  input wire logic [1:0]        vcc_sel_out,
  input wire logic [1:0]        vpp_sel_out
);
  logic [15:0]       low_cnt_reg;
  logic [7:0]        hit_cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              strobe_reg;

  // ------------------------------------------------------------
  // Strobe length and pulses since the last address move
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      low_cnt_reg <= '0;
      hit_cnt_reg <= '0;
      addr_reg    <= '0;
      strobe_reg  <= 1'b1;
    end
    else
    begin
      low_cnt_reg <= program_strobe_n_out ? '0 : low_cnt_reg + 1'b1;
      addr_reg    <= mem_addr_out;
      strobe_reg  <= program_strobe_n_out;
      if (mem_addr_out != addr_reg)
        hit_cnt_reg <= '0;
      else if (strobe_reg && !program_strobe_n_out)
        hit_cnt_reg <= hit_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_first_addr: assert property (
    $rose(busy_out) |-> mem_addr_out == '0)
    else $error("run did not start at the lowest address");
  chk_pulse_supply: assert property (
    $fell(program_strobe_n_out) |-> vcc_sel_out == 2'h1 && vpp_sel_out == 2'h1)
    else $error("strobe applied without programming supplies");
  chk_pulse_width: assert property (
    $rose(program_strobe_n_out) |-> low_cnt_reg == PULSE_CYC)
    else $error("program strobe width wrong");
  chk_retry_limit: assert property (
    $fell(program_strobe_n_out) |-> hit_cnt_reg <= MAX_RETRY)
    else $error("too many pulses at one address");
  chk_addr_step: assert property (
    busy_out && $past(busy_out) && $changed(mem_addr_out)
    |-> mem_addr_out == '0 || mem_addr_out == $past(mem_addr_out) + 1'b1)
    else $error("address skipped");
  chk_supply_end: assert property (
    $fell(busy_out) |-> vcc_sel_out == 2'h0 && vpp_sel_out == 2'h0)
    else $error("supplies not normal at end of run");
  chk_done_single: assert property (
    done_out |=> !done_out ##1 !done_out)
    else $error("done longer than one cycle");
  chk_verdict_one: assert property (
    done_out |-> !(pass_out && fail_out))
    else $error("pass and fail together");
  chk_read_strobe: assert property (
    !output_enable_n_out |-> program_strobe_n_out && mem_data_oe_n_out)
    else $error("read overlaps strobe or data drive");
endmodule : otp_programmer_checker

bind otp_programmer otp_programmer_checker #(
  .ADDR_W    (ADDR_W),
  .PULSE_CYC (PULSE_CYC),
  .MAX_RETRY (MAX_RETRY)
) chk_u (
  .clk_sys_in           (clk_sys_in),
  .arst_n_in            (arst_n_in),
  .busy_out             (busy_out),
  .done_out             (done_out),
  .pass_out             (pass_out),
  .fail_out             (fail_out),
  .mem_addr_out         (mem_addr_out),
  .mem_data_oe_n_out    (mem_data_oe_n_out),
  .output_enable_n_out  (output_enable_n_out),
  .program_strobe_n_out (program_strobe_n_out),
  .vcc_sel_out          (vcc_sel_out),
  .vpp_sel_out          (vpp_sel_out)
);
`default_nettype wire

// *** sim/otp_device_model.sv ***
// Behavioural model of the one-time-programmable memory device
`timescale 1ns/1ps
`default_nettype none
module otp_device_model #(
  parameter int         PULSE_CYC  = 8,
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'h3c,
  parameter logic [7:0] PART_CODE  = 8'hc5
) (
  input  wire logic        clk_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        data_oe_n_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        output_enable_n_in,
  input  wire logic        program_strobe_n_in,
  input  wire logic [1:0]  vcc_sel_in,
  input  wire logic [1:0]  vpp_sel_in,
  input  wire logic        id_voltage_in,
  output logic [7:0]       data_out
);
  logic [7:0]  mem [16];
  int          need [16];
  int          hits [16];
  int          pulses;
  int          corrupt;
  int          low_cyc;
  int          en_cyc;
  logic [17:0] addr_q;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  rd_val;
  logic        reading;

  // New blank part; one address may need extra pulses or read back bad
  task automatic fresh_part(input int slow_a, input int slow_n,
                            input int bad_a);
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 8'hff;
      hits[i] = 0;
      need[i] = (i == slow_a) ? slow_n : 1;
    end
    pulses = 0;
    corrupt = bad_a;
  endtask : fresh_part

  // output only when selected, enabled and strobe high
  assign reading = !chip_select_n_in && !output_enable_n_in &&
                   program_strobe_n_in;

  always_comb
  begin
    if (id_voltage_in)
      rd_val = addr_in[0] ? PART_CODE : MAKER_CODE;
    else if (vcc_sel_in == 2'h0 && int'(addr_in) == corrupt)
      rd_val = ~mem[addr_in[3:0]];
    else
      rd_val = mem[addr_in[3:0]];
  end

  // floating lines wander, so a stale sample never matches
  assign data_out = (reading && en_cyc >= 1) ? rd_val : ~last_q;

  always @(posedge clk_in)
  begin
    last_q <= data_out;
    addr_q <= addr_in;
    en_cyc <= (reading && addr_in == addr_q) ? en_cyc + 1 : 0;
    low_cyc <= program_strobe_n_in ? 0 : low_cyc + 1;
    if (program_strobe_n_in && low_cyc > 0)
    begin
      pulses <= pulses + 1;
      // only legal pulses at programming supplies take
      if (vcc_sel_in == 2'h1 && vpp_sel_in == 2'h1 && !chip_select_n_in &&
          !data_oe_n_in && low_cyc * 100 >= PULSE_CYC * 95 &&
          low_cyc * 100 <= PULSE_CYC * 105)
      begin
        hits[addr_in[3:0]] <= hits[addr_in[3:0]] + 1;
        if (hits[addr_in[3:0]] + 1 >= need[addr_in[3:0]])
          mem[addr_in[3:0]] <= data_in;
      end
    end
  end
endmodule : otp_device_model
`default_nettype wire

// *** sim/otp_rom_program_sequence_bench.sv ***
// Self-checking testbench for the memory programmer
`timescale 1ns/1ps
`default_nettype none
module otp_rom_program_sequence_bench;
  localparam int         AW    = otp_prog_pkg::ADDR_W;
  // Arbitrary identification values
  localparam logic [7:0] MAKER = 8'h3c;
  localparam logic [7:0] PART  = 8'hc5;

  logic          clk;
  logic          arst_n;
  logic          start_prog;
  logic          start_id;
  logic [AW-1:0] last_addr;
  logic [AW-1:0] src_addr;
  logic [7:0]    src_data;
  logic          busy, done, pass, fail, id_valid;
  logic [AW-1:0] fail_addr;
  logic [7:0]    maker, part;
  logic [AW-1:0] mem_addr;
  logic [7:0]    mem_dout, mem_din;
  logic          mem_oe_n, cs_n, oe_n, pgm_n, identification_high_voltage;
  logic [1:0]    vcc, vpp;
  int            errors = 0;
  int            n_checks = 0;

  function automatic logic [7:0] src_byte(input logic [AW-1:0] a);
    return {a[3:0], ~a[3:0]};
  endfunction : src_byte

  assign src_data = src_byte(src_addr);

  otp_programmer #(.PULSE_CYC(8), .SETUP_CYC(2)) dut_u (
    .clk_sys_in(clk), .arst_n_in(arst_n), .start_prog_in(start_prog),
    .start_id_in(start_id), .last_addr_in(last_addr),
    .src_addr_out(src_addr), .src_data_in(src_data), .busy_out(busy),
    .done_out(done), .pass_out(pass), .fail_out(fail),
    .fail_addr_out(fail_addr), .maker_code_out(maker),
    .part_code_out(part), .id_valid_out(id_valid),
    .mem_addr_out(mem_addr), .mem_data_out(mem_dout),
    .mem_data_oe_n_out(mem_oe_n), .mem_data_in(mem_din),
    .chip_select_n_out(cs_n), .output_enable_n_out(oe_n),
    .program_strobe_n_out(pgm_n), .vcc_sel_out(vcc), .vpp_sel_out(vpp),
    .identification_high_voltage_out(identification_high_voltage));

  otp_device_model #(.PULSE_CYC(8), .MAKER_CODE(MAKER),
                     .PART_CODE(PART)) dev_u (
    .clk_in(clk), .addr_in(mem_addr), .data_in(mem_dout),
    .data_oe_n_in(mem_oe_n), .chip_select_n_in(cs_n),
    .output_enable_n_in(oe_n), .program_strobe_n_in(pgm_n),
    .vcc_sel_in(vcc), .vpp_sel_in(vpp), .id_voltage_in(identification_high_voltage),
    .data_out(mem_din));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Start a run, poke an identification start mid-run if programming, wait for done
  task automatic run(input logic prog);
    @(posedge clk);
    start_prog <= prog;
    start_id <= !prog;
    @(posedge clk);
    start_prog <= 1'b0;
    start_id <= 1'b0;
    repeat (prog ? 20 : 1) @(posedge clk);
    start_id <= prog;
    @(posedge clk);
    start_id <= 1'b0;
    while (done !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
  endtask : run

  task automatic test_good();
    dev_u.fresh_part(99, 1, 99);
    run(1'b1);
    check(pass, 1'b1);
    check(fail, 1'b0);
    check(busy, 1'b0);
    check(id_valid, 1'b0);
    check(dev_u.pulses, 4);
    for (int a = 0; a < 4; a++)
      check(dev_u.mem[a], src_byte(AW'(a)));
  endtask : test_good

  task automatic test_retry();
    dev_u.fresh_part(2, 6, 99);
    run(1'b1);
    check(pass, 1'b1);
    check(dev_u.pulses, 9);
    check(dev_u.mem[2], src_byte(AW'(2)));
  endtask : test_retry

  task automatic test_fail();
    dev_u.fresh_part(1, 12, 99);
    run(1'b1);
    check(fail, 1'b1);
    check(pass, 1'b0);
    check(fail_addr, 1);
    check(dev_u.pulses, 14);
  endtask : test_fail

  // Byte reads bad only at normal supply, so only the final pass sees it
  task automatic test_final();
    dev_u.fresh_part(99, 1, 3);
    run(1'b1);
    check(fail, 1'b1);
    check(pass, 1'b0);
    check(fail_addr, 3);
    check(dev_u.pulses, 4);
  endtask : test_final

  task automatic test_id();
    run(1'b0);
    check(id_valid, 1'b1);
    check(maker, MAKER);
    check(part, PART);
    check(identification_high_voltage, 1'b0);
  endtask : test_id

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the several hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial
  begin
    arst_n = 1'b0;
    start_prog = 1'b0;
    start_id = 1'b0;
    last_addr = AW'(3);
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_good();
    test_retry();
    test_fail();
    test_final();
    test_id();
    stop_test();
  end
endmodule : otp_rom_program_sequence_bench
`default_nettype wire
